// ### pkg/prs_defines.svh
// Purpose: timing counts and reset values of the restart sequencer
// Assumes: core clock of 100 MHz
// Notes: step rate and preset hold are not fixed by the deck; kept small
`ifndef PRS_DEFINES_SVH
`define PRS_DEFINES_SVH
`define PRS_CLK_NS 10
// trailing-edge pulse on load point, least time, rounds up
`define PRS_PULSE_NS 1000
`define PRS_PULSE_CYC ((`PRS_PULSE_NS + `PRS_CLK_NS - 1) / `PRS_CLK_NS)
// core clocks per sequencer step
`define PRS_STEP_DIV 16
// clocks the broken-tape level is held after power-up
`define PRS_PRESET_CYC 16
// default forward search time before rewinding, in clocks
`define PRS_SEARCH_CYC 20000000
`endif

// ### pkg/prs_pkg.sv
// Purpose: types of the restart sequencer
// Assumes: nothing beyond the defines header
// Notes: state codes follow a gray sequence along the usual path
package prs_pkg;
   // sequencer states, named by their step number
   typedef enum logic [3:0] {
      st_0 = 4'h0, st_1 = 4'h1, st_2 = 4'h3, st_3 = 4'h2,
      st_4 = 4'h6, st_5 = 4'h7, st_6 = 4'h5, st_7 = 4'h4,
      st_8 = 4'hc, st_9 = 4'hd, st_a = 4'hf, st_b = 4'he,
      st_c = 4'ha, st_d = 4'hb, st_e = 4'h9, st_f = 4'h8
   } prs_state_e;
   // vacuum column load phases
   typedef enum logic [2:0] {
      vp_idle = 3'h0, vp_tension = 3'h1, vp_columns = 3'h3,
      vp_search = 3'h2, vp_done = 3'h6, vp_rewind = 3'h7
   } prs_vac_e;
endpackage : prs_pkg

// ### pkg/prs_marker_if.sv
// Purpose: marker status passed from the sensor logic to the sequencer
// Assumes: single core clock
// Notes: all members are registered by the source
`timescale 1ns/1ns
interface prs_marker_if;
   logic load_point_detect;
   logic end_marker_detect;
   logic load_point_trail_pulse;
   logic broken_tape;
   modport src (output load_point_detect, end_marker_detect,
                load_point_trail_pulse, broken_tape);
   modport dst (input load_point_detect, end_marker_detect,
                load_point_trail_pulse, broken_tape);
endinterface : prs_marker_if

// ### core/prs_marker.sv
// Purpose: load point, end marker and broken tape status
// Assumes: sensor levels synchronous to core_clk
// Notes: broken tape held high for a short time after reset
`timescale 1ns/1ns
`include "prs_defines.svh"
module prs_marker
   import prs_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // photosensor front end
   input wire logic load_point_sensor,
   input wire logic end_marker_sensor,
   input wire logic transport_unloaded,
   // status toward the sequencer
   prs_marker_if.src mk
);
   localparam logic [7:0] PULSE_CYC = 8'(`PRS_PULSE_CYC);
   localparam logic [7:0] PRESET_CYC = 8'(`PRS_PRESET_CYC);
   logic pt_det, next_pt_det, em_det, next_em_det;
   logic pulse, next_pulse, brk, next_brk;
   logic [7:0] pcnt, next_pcnt, pre_cnt, next_pre_cnt;

   // next values of the status flops
   always_comb
   begin
      next_pt_det = load_point_sensor;
      next_em_det = end_marker_sensor;
      next_pcnt = (pcnt != 8'h00) ? pcnt - 8'h01 : 8'h00;
      if (pt_det && !load_point_sensor)
         next_pcnt = PULSE_CYC;
      next_pulse = (next_pcnt != 8'h00);
      next_pre_cnt = (pre_cnt != 8'h00) ? pre_cnt - 8'h01 : 8'h00;
      // power-up preset, then both markers or an unloaded deck
      next_brk = (next_pre_cnt != 8'h00)
         || (load_point_sensor && end_marker_sensor)
         || transport_unloaded;
   end

   // reset puts broken tape high so the load flop downstream presets
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         pt_det <= 1'b0;
         em_det <= 1'b0;
         pcnt <= 8'h00;
         pulse <= 1'b0;
         pre_cnt <= PRESET_CYC;
         brk <= 1'b1;
      end
      else
      begin
         pt_det <= next_pt_det;
         em_det <= next_em_det;
         pcnt <= next_pcnt;
         pulse <= next_pulse;
         pre_cnt <= next_pre_cnt;
         brk <= next_brk;
      end
   end

   assign mk.load_point_detect = pt_det;
   assign mk.end_marker_detect = em_det;
   assign mk.load_point_trail_pulse = pulse;
   assign mk.broken_tape = brk;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_pt_follow: assert property (
      load_point_sensor |=> pt_det) else $error("load point not shown");
   a_trail_start: assert property (
      $fell(pt_det) |-> pulse[*8]) else $error("trailing pulse missing");
   a_trail_len: assert property (
      $rose(pulse) |-> ##99 pulse) else $error("trailing pulse short");
   a_em_follow: assert property (
      end_marker_sensor |=> em_det) else $error("end marker not shown");
   a_brk_both: assert property (
      load_point_sensor && end_marker_sensor |=> brk)
      else $error("both markers without broken tape");
   a_brk_unload: assert property (
      transport_unloaded |=> brk) else $error("unloaded, no broken tape");
   a_brk_preset: assert property (
      $rose(rst_n) |-> brk[*8]) else $error("no power-up preset");
   c_trail_pulse: cover property ($rose(pulse));
endmodule : prs_marker

// ### core/prs_sequencer.sv
// Purpose: restart sequencer bringing the transport back after power loss
// Assumes: all inputs synchronous to core_clk; requests are levels
// Notes: steps advance once per divided step enable
`timescale 1ns/1ns
`include "prs_defines.svh"
module prs_sequencer
   import prs_pkg::*;
#(
   parameter int SEARCH_CYC = `PRS_SEARCH_CYC
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // photosensors and deck state
   input wire logic load_point_sensor,
   input wire logic end_marker_sensor,
   input wire logic transport_unloaded,
   input wire logic deck_online,
   input wire logic power_ok,
   // control from outside
   input wire logic master_clear_in,
   input wire logic remote_load_request_n,
   input wire logic auto_restart,
   input wire logic vacuum_column,
   // marker status
   output logic load_point_detect,
   output logic end_marker_detect,
   output logic load_point_trail_pulse,
   output logic broken_tape,
   // sequencer commands
   output logic broken_tape_force,
   output logic load_set_cmd,
   output logic on_tape_set_cmd,
   output logic online_set_cmd,
   output logic enable_out,
   output logic tension_cmd,
   output logic column_load_cmd,
   output logic search_fwd_cmd,
   output logic rewind_cmd,
   output logic [3:0] seq_state
);
   localparam logic [4:0] STEP_DIV = 5'(`PRS_STEP_DIV - 1);
   localparam logic [31:0] SEARCH_LAST = 32'(SEARCH_CYC - 1);

   prs_marker_if mk ();
   prs_state_e state, next_state;
   prs_vac_e vac, next_vac;
   logic [4:0] div, next_div;
   logic step_en;
   logic [31:0] tmr, next_tmr;
   logic was_online, next_was_online, pwr_prev, next_pwr_prev;
   logic req_armed, next_req_armed, jump;
   logic next_bkf, next_ld, next_ot, next_onl, next_en;
   logic next_ten, next_col, next_srch, next_rew;

   // marker logic shares the sensor inputs
   prs_marker i_prs_marker (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .load_point_sensor(load_point_sensor),
      .end_marker_sensor(end_marker_sensor),
      .transport_unloaded(transport_unloaded),
      .mk(mk)
   );
   assign load_point_detect = mk.load_point_detect;
   assign end_marker_detect = mk.end_marker_detect;
   assign load_point_trail_pulse = mk.load_point_trail_pulse;
   assign broken_tape = mk.broken_tape;

   // step divider: one enable pulse every STEP_DIV+1 clocks
   always_comb
   begin
      step_en = (div == STEP_DIV);
      next_div = step_en ? 5'h00 : div + 5'h01;
   end

   // restart memory: online status is captured only in E or F with power
   // good, so the offline state forced by a power loss cannot erase it
   always_comb
   begin
      next_pwr_prev = power_ok;
      next_was_online = (power_ok && (state == st_e || state == st_f))
         ? deck_online : was_online;
      next_req_armed = req_armed;
      if (state == st_e || state == st_f)
         next_req_armed = 1'b0;
      // arming wins over the clear when power returns unloaded
      if (power_ok && !pwr_prev && transport_unloaded)
         next_req_armed = 1'b1;
      jump = (req_armed && !remote_load_request_n)
         || (auto_restart && was_online);
   end

   // sequencer next state; a step moves it at most once
   always_comb
   begin
      next_state = state;
      if (step_en)
      begin
         unique case (state)
            st_0: next_state = master_clear_in ? st_0 : st_1;
            st_1: next_state = master_clear_in ? st_0 : st_2;
            st_2: next_state = st_3;
            st_3: next_state = st_4;
            st_4: next_state = jump ? st_7 : st_f;
            st_5: next_state = st_6;
            st_6: next_state = st_7;
            st_7: next_state = st_8;
            st_8: next_state = st_9;
            // vacuum decks hold here until the load sub-sequence ends
            st_9: next_state = (!vacuum_column || vac == vp_done) ? st_a
                                                                   : st_9;
            st_a: next_state = st_b;
            st_b: next_state = st_c;
            st_c: next_state = st_d;
            st_d: next_state = st_e;
            st_e: next_state = master_clear_in ? st_0 : st_e;
            st_f: next_state = mk.broken_tape ? st_0 : st_f;
         endcase
         if (!power_ok)
            next_state = st_0;
      end
      next_bkf = (next_state == st_0 || next_state == st_1);
      next_ld = (next_state == st_8 || next_state == st_9);
      next_ot = (next_state == st_a || next_state == st_b);
      next_onl = (next_state == st_c || next_state == st_d);
      next_en = (next_state == st_e || next_state == st_f);
   end

   // vacuum column load: tension, columns, search, rewind on timeout
   always_comb
   begin
      next_vac = vac;
      next_tmr = tmr;
      if (state != st_9 || !vacuum_column)
      begin
         next_vac = vp_idle;
         next_tmr = 32'h0000_0000;
      end
      else
      begin
         unique case (vac)
            vp_idle: next_vac = vp_tension;
            vp_tension: if (step_en) next_vac = vp_columns;
            vp_columns: if (step_en) next_vac = vp_search;
            vp_search:
            begin
               next_tmr = tmr + 32'h0000_0001;
               if (mk.load_point_detect)
                  next_vac = vp_done;
               else if (tmr == SEARCH_LAST)
                  next_vac = vp_rewind;
            end
            vp_rewind: if (mk.load_point_detect) next_vac = vp_done;
            vp_done: next_vac = vp_done;
            default: next_vac = vp_idle;
         endcase
      end
      next_ten = (next_vac == vp_tension);
      next_col = (next_vac == vp_columns);
      next_srch = (next_vac == vp_search);
      next_rew = (next_vac == vp_rewind);
   end

   // all state registers; outputs come straight from flops
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state <= st_0;
         div <= 5'h00;
         vac <= vp_idle;
         tmr <= 32'h0000_0000;
         was_online <= 1'b0;
         pwr_prev <= 1'b0;
         req_armed <= 1'b0;
         broken_tape_force <= 1'b1;
         load_set_cmd <= 1'b0;
         on_tape_set_cmd <= 1'b0;
         online_set_cmd <= 1'b0;
         enable_out <= 1'b0;
         tension_cmd <= 1'b0;
         column_load_cmd <= 1'b0;
         search_fwd_cmd <= 1'b0;
         rewind_cmd <= 1'b0;
      end
      else
      begin
         state <= next_state;
         div <= next_div;
         vac <= next_vac;
         tmr <= next_tmr;
         was_online <= next_was_online;
         pwr_prev <= next_pwr_prev;
         req_armed <= next_req_armed;
         broken_tape_force <= next_bkf;
         load_set_cmd <= next_ld;
         on_tape_set_cmd <= next_ot;
         online_set_cmd <= next_onl;
         enable_out <= next_en;
         tension_cmd <= next_ten;
         column_load_cmd <= next_col;
         search_fwd_cmd <= next_srch;
         rewind_cmd <= next_rew;
      end
   end
   assign seq_state = state;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_mclr_return: assert property (
      step_en && power_ok && master_clear_in && (state inside {st_0, st_1})
      |=> state == st_0 && broken_tape_force)
      else $error("master clear did not return to 0");
   a_four_jump: assert property (
      step_en && power_ok && state == st_4
      |=> state == (jump ? st_7 : st_f))
      else $error("wrong exit from state 4");
   a_set_cmds: assert property (
      $rose(load_set_cmd) |-> load_set_cmd[*2] ##0 state == st_8)
      else $error("load set not tied to state 8");
   a_e_holds: assert property (
      state == st_e && !master_clear_in && power_ok |=> state == st_e
      && enable_out) else $error("enable state left early");
   a_f_exit: assert property (
      step_en && power_ok && state == st_f && mk.broken_tape
      |=> state == st_0) else $error("broken tape did not end F");
   a_vac_rewind: assert property (
      vac == vp_search && tmr == SEARCH_LAST && !mk.load_point_detect
      && state == st_9 && vacuum_column |=> rewind_cmd)
      else $error("no rewind on timeout");
   a_no_restart: assert property (
      step_en && power_ok && state == st_4 && !was_online && !req_armed
      |=> state == st_f) else $error("restart while offline");
   a_step_once: assert property (
      state != $past(state) |-> $past(step_en))
      else $error("state moved without a step");
   c_reach_e: cover property (state == st_e);
   c_reach_f: cover property (state == st_f);
   c_req_jump: cover property (state == st_4 ##1 state == st_7);
   c_vac_rewind: cover property ($rose(rewind_cmd));
endmodule : prs_sequencer

// ### verification/prs_far_side.sv
// Purpose: far side model, photosensors and interface control
// Assumes: the bench states its wishes one clock ahead
// Notes: a load command marks the deck loaded; rewind finds load point
`timescale 1ns/1ns
module prs_far_side
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // wishes of the bench
   input wire logic want_start_mark,
   input wire logic want_end_mark,
   input wire logic want_unloaded,
   input wire logic want_req,
   // commands from the sequencer
   input wire logic load_set_cmd,
   input wire logic rewind_cmd,
   // levels toward the sequencer
   output logic load_point_sensor,
   output logic end_marker_sensor,
   output logic transport_unloaded,
   output logic remote_load_request_n
);
   logic [3:0] rew_cnt;
   logic unl_q;
   // rewind takes a while to reach the marker, never at once
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         rew_cnt <= 4'h0;
         unl_q <= 1'b0;
         load_point_sensor <= 1'b0;
         end_marker_sensor <= 1'b0;
         transport_unloaded <= 1'b0;
         remote_load_request_n <= 1'b1;
      end
      else
      begin
         rew_cnt <= rewind_cmd ? rew_cnt + {3'h0, rew_cnt != 4'hf} : 4'h0;
         load_point_sensor <= want_start_mark
            | (rewind_cmd & rew_cnt == 4'hf);
         end_marker_sensor <= want_end_mark;
         unl_q <= want_unloaded;
         // loading clears the level until the bench unloads again
         if (load_set_cmd | !want_unloaded)
            transport_unloaded <= 1'b0;
         else if (!unl_q)
            transport_unloaded <= 1'b1;
         remote_load_request_n <= !want_req;
      end
   end
endmodule : prs_far_side

// ### verification/prs_sequencer_bench.sv
// Purpose: self-checking bench of the restart sequencer
// Assumes: far side model answers one clock after each wish
// Notes: search timeout shortened to 50 clocks to keep the run short
`timescale 1ns/1ns
module prs_sequencer_bench
   import prs_pkg::*;
;
   logic core_clk, rst_n, want_start_mark, want_end_mark, want_unloaded;
   logic want_req;
   logic deck_online, power_ok, master_clear_in, auto_restart;
   logic vacuum_column, load_point_sensor, end_marker_sensor;
   logic transport_unloaded, remote_load_request_n;
   logic load_point_detect, end_marker_detect, load_point_trail_pulse;
   logic broken_tape, broken_tape_force, load_set_cmd, on_tape_set_cmd;
   logic online_set_cmd, enable_out, tension_cmd, rewind_cmd;
   logic column_load_cmd, search_fwd_cmd;
   logic [3:0] seq_state;
   int n_mismatch = 0;
   int tests_run = 0;
   int cyc = 0;

   prs_sequencer #(.SEARCH_CYC(50)) i_prs_sequencer (
      .core_clk(core_clk), .rst_n(rst_n),
      .load_point_sensor(load_point_sensor),
      .end_marker_sensor(end_marker_sensor),
      .transport_unloaded(transport_unloaded), .deck_online(deck_online),
      .power_ok(power_ok), .master_clear_in(master_clear_in),
      .remote_load_request_n(remote_load_request_n),
      .auto_restart(auto_restart), .vacuum_column(vacuum_column),
      .load_point_detect(load_point_detect),
      .end_marker_detect(end_marker_detect),
      .load_point_trail_pulse(load_point_trail_pulse),
      .broken_tape(broken_tape),
      .broken_tape_force(broken_tape_force), .load_set_cmd(load_set_cmd),
      .on_tape_set_cmd(on_tape_set_cmd), .online_set_cmd(online_set_cmd),
      .enable_out(enable_out), .tension_cmd(tension_cmd),
      .column_load_cmd(column_load_cmd), .search_fwd_cmd(search_fwd_cmd),
      .rewind_cmd(rewind_cmd),
      .seq_state(seq_state));

   prs_far_side i_prs_far_side (
      .core_clk(core_clk), .rst_n(rst_n),
      .want_start_mark(want_start_mark), .want_end_mark(want_end_mark),
      .want_unloaded(want_unloaded),
      .want_req(want_req), .load_set_cmd(load_set_cmd),
      .rewind_cmd(rewind_cmd), .load_point_sensor(load_point_sensor),
      .end_marker_sensor(end_marker_sensor),
      .transport_unloaded(transport_unloaded),
      .remote_load_request_n(remote_load_request_n));

   // 100 MHz core clock
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic close_out();
      if (n_mismatch == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // sample just after the edge so its updates have landed
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge core_clk);
         #1;
      end
   endtask : tick

   // a skipped or wrong state never matches and runs out the wait
   task automatic walk(input logic [3:0] code);
      int i;
      i = 0;
      while (seq_state !== code && i < 100)
      begin
         tick(1);
         i++;
      end
      check(seq_state, code);
   endtask : walk

   // vacuum phases are one-hot: 0 tension, 1 columns, 2 search, 3 rewind
   task automatic wait_bit(input int idx);
      int i;
      logic [3:0] vb;
      i = 0;
      vb = 4'h0;
      while (vb[idx] !== 1'b1 && i < 200)
      begin
         vb = {rewind_cmd, search_fwd_cmd, column_load_cmd, tension_cmd};
         if (vb[idx] !== 1'b1)
         begin
            tick(1);
            i++;
         end
      end
      check(vb, 8'h01 << idx);
   endtask : wait_bit

   task automatic t_normal();
      check({broken_tape_force, broken_tape}, 2'b11);
      walk(st_1);
      check(broken_tape_force, 1'b1);
      @(posedge core_clk);
      master_clear_in <= 1'b1;
      walk(st_0);
      tick(40);
      check(seq_state, st_0);
      master_clear_in <= 1'b0;
      // an unarmed remote request must not divert state 4
      want_req <= 1'b1;
      check(broken_tape, 1'b0);
      walk(st_1);
      walk(st_2);
      walk(st_3);
      walk(st_4);
      walk(st_f);
      check({enable_out, broken_tape_force}, 2'b10);
      tick(40);
      check(seq_state, st_f);
      @(posedge core_clk);
      want_start_mark <= 1'b1;
      want_end_mark <= 1'b1;
      tick(3);
      check(broken_tape, 1'b1);
      walk(st_0);
      want_start_mark <= 1'b0;
      want_end_mark <= 1'b0;
      want_req <= 1'b0;
   endtask : t_normal

   task automatic t_markers();
      int n;
      // the trailing pulse left by the previous scenario must die out
      tick(120);
      want_start_mark <= 1'b1;
      want_end_mark <= 1'b1;
      tick(1);
      check({load_point_detect, end_marker_detect}, 2'b00);
      tick(1);
      check({load_point_detect, end_marker_detect}, 2'b11);
      want_start_mark <= 1'b0;
      want_end_mark <= 1'b0;
      n = 0;
      repeat (300)
      begin
         tick(1);
         n += load_point_trail_pulse;
      end
      check(8'(n), 8'h64);
   endtask : t_markers

   task automatic t_restart();
      walk(st_f);
      auto_restart <= 1'b1;
      deck_online <= 1'b1;
      tick(2);
      power_ok <= 1'b0;
      // a full step with power low forces state 0
      tick(20);
      walk(st_0);
      deck_online <= 1'b0;
      power_ok <= 1'b1;
      walk(st_4);
      walk(st_7);
      walk(st_8);
      power_ok <= 1'b0;
      walk(st_0);
      auto_restart <= 1'b0;
   endtask : t_restart

   // power is still low here, so its return below arms the request
   task automatic t_remote();
      want_unloaded <= 1'b1;
      tick(2);
      check(broken_tape, 1'b1);
      power_ok <= 1'b1;
      want_req <= 1'b1;
      vacuum_column <= 1'b1;
      walk(st_4);
      walk(st_7);
      walk(st_8);
      check(load_set_cmd, 1'b1);
      walk(st_9);
      wait_bit(0);
      wait_bit(1);
      wait_bit(2);
      wait_bit(3);
      walk(st_a);
      check({on_tape_set_cmd, load_set_cmd}, 2'b10);
      walk(st_b);
      walk(st_c);
      check({online_set_cmd, on_tape_set_cmd}, 2'b10);
      walk(st_d);
      walk(st_e);
      check({enable_out, online_set_cmd}, 2'b10);
      want_req <= 1'b0;
      want_unloaded <= 1'b0;
      tick(40);
      check(seq_state, st_e);
      master_clear_in <= 1'b1;
      walk(st_0);
      master_clear_in <= 1'b0;
   endtask : t_remote

   // cut a hang short
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         close_out();
      end
   end

   initial
   begin
      {rst_n, want_start_mark, want_end_mark, want_unloaded} = 4'h0;
      want_req = 1'b0;
      {deck_online, master_clear_in, auto_restart, vacuum_column} = 4'h0;
      power_ok = 1'b1;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      tick(1);
      t_normal();
      t_markers();
      t_restart();
      t_remote();
      close_out();
   end
endmodule : prs_sequencer_bench
